// ==== fan_pkg.sv ====
// Package: register map, field layout and reset values of the fiber AN regs
package fan_pkg;
  // Register offsets (12-bit register space)
  localparam logic [11:0] OFS_CTRL = 12'hC00;
  localparam logic [11:0] OFS_IDENT_HIGH = 12'hC02;
  localparam logic [11:0] OFS_IDENT_LOW = 12'hC03;
  localparam logic [11:0] OFS_ADVERTISE = 12'hC04;
  localparam logic [11:0] OFS_PARTNER = 12'hC05;
  // Field positions
  localparam int POS_MORE_PAGES = 15;
  localparam int POS_ACK = 14;
  localparam int POS_FAULT = 12;
  localparam int POS_ASYM = 8;
  localparam int POS_SYM = 7;
  localparam int POS_HALF = 6;
  localparam int POS_FULL = 5;
  localparam int POS_RESTART = 9;
  localparam int POS_MODEL = 4;
  localparam int POS_ORG_LOWER = 10;
  // Writable bits of the advertisement register
  localparam logic [15:0] ADV_WMASK = 16'hB1E0;
  // Meaningful bits of the partner ability register
  localparam logic [15:0] PARTNER_MASK = 16'hF1E0;
  // Reset values
  localparam logic [15:0] ADV_RESET = 16'h0020;
  localparam logic [15:0] PARTNER_RESET = 16'h0000;
  // Fault codes
  localparam logic [1:0] FAULT_LINK_OK = 2'h0;
  localparam logic [1:0] FAULT_OFFLINE = 2'h1;
  localparam logic [1:0] FAULT_LINK_FAIL = 2'h2;
  localparam logic [1:0] FAULT_AN_ERROR = 2'h3;
endpackage

// ==== fan_sync.sv ====
// Three-stage input synchroniser for signals from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module fan_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] out_r;

  // Stage one feeds only stage two; the output moves when two and three agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end
    else if (ce)
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        out_r <= s3_r;
    end
  end

  assign dout = out_r;
endmodule
`default_nettype wire

// ==== fan_regs.sv ====
// Fiber auto-negotiation advertisement, partner ability and ident registers
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module fan_regs #(
  parameter logic [13:0] ORG_IDENT_UPPER = 14'h0155, // Arbitrary value
  parameter logic [5:0] ORG_IDENT_LOWER = 6'h15, // Arbitrary value
  parameter logic [5:0] MODEL_NUMBER = 6'h2A, // Arbitrary value
  parameter logic [3:0] REVISION_NUMBER = 4'h3 // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  // Register port
  input wire logic [11:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // Received base page from the link (asynchronous to CLK_SYS)
  input wire logic [15:0] RX_PAGE,
  input wire logic RX_PAGE_VALID,
  // Negotiation engine
  input wire logic AN_RESTART_DONE,
  output logic AN_RESTART,
  output logic [15:0] TX_PAGE
);
  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  logic [16:0] sync_in;
  logic [16:0] sync_out;
  logic valid_s;
  logic [15:0] page_s;
  logic valid_d_r;
  logic page_strobe;

  assign sync_in = {RX_PAGE_VALID, RX_PAGE};

  fan_sync #(.WIDTH(17)) u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .din(sync_in),
    .dout(sync_out)
  );

  assign valid_s = sync_out[16];
  assign page_s = sync_out[15:0];
  // Rising valid marks one new page; the page must be held steady with it
  assign page_strobe = valid_s & ~valid_d_r;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  logic hit_ctrl;
  logic hit_high;
  logic hit_low;
  logic hit_adv;
  logic hit_partner;
  logic wr_adv;
  logic wr_ctrl;

  assign hit_ctrl = (REG_ADDR == fan_pkg::OFS_CTRL);
  assign hit_high = (REG_ADDR == fan_pkg::OFS_IDENT_HIGH);
  assign hit_low = (REG_ADDR == fan_pkg::OFS_IDENT_LOW);
  assign hit_adv = (REG_ADDR == fan_pkg::OFS_ADVERTISE);
  assign hit_partner = (REG_ADDR == fan_pkg::OFS_PARTNER);
  assign wr_adv = REG_WR & hit_adv;
  assign wr_ctrl = REG_WR & hit_ctrl;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [15:0] adv_r;
  logic [15:0] adv_nxt;
  logic [15:0] partner_r;
  logic [15:0] partner_nxt;
  logic restart_r;
  logic restart_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [15:0] ident_high;
  logic [15:0] ident_low;
  logic [15:0] ctrl_view;

  // Only writable fields take the write data
  // read zero
  // Masking keeps ack, reserved and low bits at zero
  assign adv_nxt = wr_adv
    ? (REG_WDATA & fan_pkg::ADV_WMASK)
    : adv_r;

  // capture page
  // Last page is held until the next one; reserved bits dropped
  assign partner_nxt = page_strobe
    ? (page_s & fan_pkg::PARTNER_MASK)
    : partner_r;

  // self clear
  // Set wins over the engine's done pulse so a restart is never lost
  assign restart_nxt = (wr_ctrl & REG_WDATA[fan_pkg::POS_RESTART])
    | (restart_r & ~AN_RESTART_DONE);

  assign ident_high = {2'h0, ORG_IDENT_UPPER};
  assign ident_low = {ORG_IDENT_LOWER, MODEL_NUMBER, REVISION_NUMBER};
  assign ctrl_view = 16'h0000 | (16'(restart_r) << fan_pkg::POS_RESTART);

  // Read mux; unmapped addresses read zero
  assign rdata_nxt = !REG_RD ? 16'h0000
    : hit_high ? ident_high
    : hit_low ? ident_low
    : hit_adv ? adv_r
    : hit_partner ? partner_r
    : hit_ctrl ? ctrl_view
    : 16'h0000;

  // State update, frozen while the enable is low
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      adv_r <= fan_pkg::ADV_RESET;
      partner_r <= fan_pkg::PARTNER_RESET;
      restart_r <= 1'b0;
      rdata_r <= 16'h0000;
      valid_d_r <= 1'b0;
    end
    else if (CE)
    begin
      adv_r <= adv_nxt;
      partner_r <= partner_nxt;
      restart_r <= restart_nxt;
      rdata_r <= rdata_nxt;
      valid_d_r <= valid_s;
    end
  end

  // Outputs come straight from flip-flops
  assign REG_RDATA = rdata_r;
  assign AN_RESTART = restart_r;
  assign TX_PAGE = adv_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  AST_IDENT_HIGH: assert property (
    (CE && REG_RD && hit_high) |=> (REG_RDATA == ident_high))
    else $error("ident high readback wrong");
  AST_IDENT_LOW: assert property (
    (CE && REG_RD && hit_low) |=> (REG_RDATA == ident_low))
    else $error("ident low readback wrong");
  AST_NEXT_PAGE_WR: assert property (
    (CE && wr_adv) |=> (TX_PAGE[15] == $past(REG_WDATA[15])))
    else $error("next page bit not written");
  AST_FAULT_WR: assert property (
    (CE && wr_adv) |=> (TX_PAGE[13:12] == $past(REG_WDATA[13:12])))
    else $error("fault code not written");
  AST_ASYM_WR: assert property (
    (CE && wr_adv) |=> (TX_PAGE[8] == $past(REG_WDATA[8])))
    else $error("asym pause not written");
  AST_SYM_WR: assert property (
    (CE && wr_adv) |=> (TX_PAGE[7] == $past(REG_WDATA[7])))
    else $error("pause not written");
  AST_DUPLEX_WR: assert property (
    (CE && wr_adv) |=> (TX_PAGE[6:5] == $past(REG_WDATA[6:5])))
    else $error("duplex bits not written");
  AST_ADV_ZERO: assert property (
    (TX_PAGE & ~fan_pkg::ADV_WMASK) == 16'h0000)
    else $error("advert reserved bits set");
  AST_PARTNER_CAP: assert property (
    (CE && page_strobe) |=> (partner_r[15:12] == $past(page_s[15:12])))
    else $error("partner page not captured");
  AST_PARTNER_HOLD: assert property (
    (CE && !page_strobe) |=> $stable(partner_r))
    else $error("partner page changed unprompted");
  AST_PARTNER_RSVD: assert property (
    (partner_r & ~fan_pkg::PARTNER_MASK) == 16'h0000)
    else $error("partner reserved bits set");
  AST_RESTART_HOLD: assert property (
    (AN_RESTART && !AN_RESTART_DONE && CE) |=> AN_RESTART)
    else $error("restart dropped early");
  AST_RESTART_CLEAR: assert property (
    (AN_RESTART && AN_RESTART_DONE && CE
      && !(wr_ctrl && REG_WDATA[fan_pkg::POS_RESTART])) |=> !AN_RESTART)
    else $error("restart not cleared after done");
  AST_READ_ONE: assert property (
    (CE && !REG_RD) |=> (REG_RDATA == 16'h0000))
    else $error("read data outside read slot");

  COV_ADV_WRITE: cover property (CE && wr_adv ##1 REG_RD && hit_adv);
  COV_PAGE_RX: cover property (CE && page_strobe);
  COV_RESTART: cover property (AN_RESTART ##[1:20] !AN_RESTART);
endmodule
`default_nettype wire

// ==== fan_lp_model.sv ====
// Remote link partner model: sends base pages, answers restart
`timescale 1ns/10ps
`default_nettype none
module fan_lp_model (
  // Clock
  input wire logic clk,
  // Link side
  input wire logic an_restart,
  output logic [15:0] rx_page,
  output logic rx_page_valid,
  output logic an_restart_done
);
  int dly = 3;
  initial
  begin
    rx_page = 16'h0000;
    rx_page_valid = 1'b0;
    an_restart_done = 1'b0;
  end
  // Page settles before valid; lines scrambled once released so a
  // stale page never passes for a fresh one
  task automatic send(input logic [15:0] p);
    rx_page <= p;
    repeat (5) @(posedge clk);
    rx_page_valid <= 1'b1;
    repeat (6) @(posedge clk);
    rx_page_valid <= 1'b0;
    repeat (5) @(posedge clk);
    rx_page <= ~p;
    @(posedge clk);
  endtask
  always
  begin
    @(posedge clk iff an_restart);
    repeat (dly) @(posedge clk);
    an_restart_done <= 1'b1;
    @(posedge clk);
    an_restart_done <= 1'b0;
  end
endmodule
`default_nettype wire

// ==== fan_regs_test.sv ====
// Self-checking bench for the fiber negotiation register bank
`timescale 1ns/10ps
`default_nettype none
module fan_regs_test;
  localparam logic [13:0] UPPER = 14'h1234; // Arbitrary value
  localparam logic [5:0] LOWER = 6'h2D; // Arbitrary value
  localparam logic [5:0] MODEL = 6'h11; // Arbitrary value
  localparam logic [3:0] REV = 4'h6; // Arbitrary value
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic rd_q = 1'b0;
  logic [11:0] REG_ADDR = 12'h000;
  logic [15:0] REG_WDATA = 16'h0000;
  logic [15:0] adv_m = 16'h0020;
  logic [15:0] REG_RDATA, RX_PAGE, TX_PAGE, d;
  logic RX_PAGE_VALID, AN_RESTART_DONE, AN_RESTART;
  logic [15:0] exp_q[$];
  int err_count = 0;
  int check_count = 0;
  int seed = 43;
  int n, k;
  fan_regs #(.ORG_IDENT_UPPER(UPPER), .ORG_IDENT_LOWER(LOWER),
    .MODEL_NUMBER(MODEL), .REVISION_NUMBER(REV)) i_dut (
    .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .RX_PAGE(RX_PAGE),
    .RX_PAGE_VALID(RX_PAGE_VALID), .AN_RESTART_DONE(AN_RESTART_DONE),
    .AN_RESTART(AN_RESTART), .TX_PAGE(TX_PAGE));
  fan_lp_model i_lp (.clk(CLK_SYS), .an_restart(AN_RESTART),
    .rx_page(RX_PAGE), .rx_page_valid(RX_PAGE_VALID),
    .an_restart_done(AN_RESTART_DONE));
  initial
    forever #4 CLK_SYS = ~CLK_SYS;
  // -----------------------------
  // Bus tasks and comparison
  // -----------------------------
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus cycle; each signal set once per edge, so calls chain freely
  task automatic acc(input logic w, input logic r, input logic [11:0] a,
    input logic [15:0] v);
    REG_WR <= w;
    REG_RD <= r;
    REG_ADDR <= a;
    REG_WDATA <= v;
    @(posedge CLK_SYS);
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    acc(1'b1, 1'b0, a, v);
    if (a == fan_pkg::OFS_ADVERTISE && CE)
      adv_m <= v & 16'hB1E0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    acc(1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic idle();
    acc(1'b0, 1'b0, 12'h000, 16'h0000);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Results are judged at the falling edge, well clear of launches
  always @(posedge CLK_SYS)
    rd_q <= REG_RD & CE & ~RST;
  always @(negedge CLK_SYS)
  begin
    chk("tx page", adv_m, TX_PAGE);
    if (rd_q)
      chk("read data", exp_q.pop_front(), REG_RDATA);
    else
      chk("idle read data", 16'h0000, REG_RDATA);
  end
  initial
  begin
    #100000;
    err_count++;
    conclude();
  end
  // -----------------------------
  // Scenarios
  // -----------------------------
  initial
  begin
    repeat (4) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    rd(fan_pkg::OFS_IDENT_HIGH, {2'b00, UPPER});
    rd(fan_pkg::OFS_IDENT_LOW, {LOWER, MODEL, REV});
    rd(fan_pkg::OFS_ADVERTISE, 16'h0020);
    rd(fan_pkg::OFS_PARTNER, 16'h0000);
    rd(12'hC0F, 16'h0000);
    for (n = 0; n < 4; n++)
    begin
      d = $random(seed);
      d[13:12] = n[1:0];
      wr(fan_pkg::OFS_ADVERTISE, d);
      rd(fan_pkg::OFS_ADVERTISE, d & 16'hB1E0);
    end
    wr(fan_pkg::OFS_ADVERTISE, 16'hFFFF);
    wr(fan_pkg::OFS_IDENT_HIGH, 16'hFFFF);
    rd(fan_pkg::OFS_IDENT_HIGH, {2'b00, UPPER});
    idle();
    // A write while frozen must not land
    CE <= 1'b0;
    wr(fan_pkg::OFS_ADVERTISE, 16'h0000);
    CE <= 1'b1;
    rd(fan_pkg::OFS_ADVERTISE, 16'hB1E0);
    idle();
    for (n = 0; n < 6; n++)
    begin
      d = n ? $random(seed) : 16'hFFFF;
      d[13:12] = n[1:0];
      i_lp.send(d);
      rd(fan_pkg::OFS_PARTNER, d & 16'hF1E0);
      idle();
    end
    // Slow engine first, then a prompt one
    for (n = 0; n < 2; n++)
    begin
      i_lp.dly = n ? 1 : 20;
      wr(fan_pkg::OFS_CTRL, 16'h0200);
      rd(fan_pkg::OFS_CTRL, 16'h0200);
      idle();
      @(negedge CLK_SYS);
      chk("restart", 16'h0001, {15'h0000, AN_RESTART});
      for (k = 0; k < 60 && AN_RESTART !== 1'b0; k++)
        @(negedge CLK_SYS);
      chk("restart", 16'h0000, {15'h0000, AN_RESTART});
      @(posedge CLK_SYS);
      rd(fan_pkg::OFS_CTRL, 16'h0000);
      idle();
    end
    // Reset in mid-run restores the default page
    RST <= 1'b1;
    adv_m <= 16'h0020;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    rd(fan_pkg::OFS_ADVERTISE, 16'h0020);
    rd(fan_pkg::OFS_PARTNER, 16'h0000);
    idle();
    repeat (2) @(posedge CLK_SYS);
    conclude();
  end
endmodule
`default_nettype wire
